/* File: hw/cocr_regs.sv */
// Purpose: six 8-bit output and loop configuration registers with watchdog
// Assumes: host port is a simple synchronous byte access, already decoded from the serial link
// Notes:   read data registered one cycle after rd_i; reserved bits fixed
// Behaviour
// RULE1: watchdog counts only when enabled; select picks 250ms, 500ms, 2s or 4s.
// RULE2: alarm bit at 0x20 bit 0 is read only, resets to zero.
// RULE3: alarm sets on watchdog timeout without host activity; clears on reconfiguration.
// RULE4: 0x1f bit 3 selects first or third order for second loop.
// RULE5: 0x1f bit 2 enables second loop channel 2, resets to one.
// RULE6: 0x1f bit 1 enables the extra third loop pole, read and write.
// RULE7: 0x21 bit 2 tristates pairs with bias off during power down.
// RULE8: 0x21 bits 1 and 0: zero inverts the B output of each pair.
// RULE9: 0x22 bit 7 picks first or third divider for pair one, default third.
// RULE10: 0x23 bit 7 picks first or third divider for pair two, default first.
// RULE11: type fields bits 5:4: 00 cmos pairs, 11 low power hcsl, others reserved.
// RULE12: bit 1 of each pair register sets cmos slew strong when one.
// RULE13: bit 0 of each pair register enables the B cmos output.
// RULE14: 0x24 bit 7 low powers the chip down; resets to one.
// RULE15: 0x24 bit 4 low gives slow free clock; else bit 3 picks divider.
// RULE16: 0x24 bits 1 and 0 enable fourth divider channels 3 and 2.
// RULE17: frequency switch selector picks one of four stored feedback settings.
// RULE18: host writes reserved bits with defaults and ignores their read value.
`timescale 1ns/1ps
module cocr_regs
    import cocr_pkg::*;
#(
    parameter int WD_TICK_CYC = COCR_TICK_CYC
) (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // host register port
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    // frequency switch selector held in a lower register
    input  wire logic [1:0] freq_switch_select_i,
    // second loop
    output logic            second_loop_order_sel_o,
    output logic            second_loop_chan2_enable_o,
    output logic            second_loop_extra_pole_enable_o,
    // frequency switch
    output logic            freq_switch_enable_o,
    output logic [1:0]      freq_switch_apply_o,
    // watchdog
    output logic            wdog_enable_o,
    output logic            wdog_alarm_o,
    // differential pairs
    output logic            pair_powerdown_tristate_o,
    output logic            pair_one_b_polarity_o,
    output logic            pair_two_b_polarity_o,
    output logic            pair_one_source_sel_o,
    output logic            pair_two_source_sel_o,
    output logic            pair_one_low_power_hcsl_type_o,
    output logic            pair_two_low_power_hcsl_type_o,
    output logic            pair_one_cmos_o,
    output logic            pair_two_cmos_o,
    output logic            pair_one_slew_o,
    output logic            pair_two_slew_o,
    output logic            pair_one_b_enable_o,
    output logic            pair_two_b_enable_o,
    output logic            pair_hiz_o,
    // chip and single ended
    output logic            chip_powerdown_n_o,
    output logic            ref_free_run_o,
    output logic            ref_enable_o,
    output logic            single_out1_slow_clock_o,
    output logic            single_out1_divider_sel_o,
    output logic            fourth_divider_chan3_enable_o,
    output logic            fourth_divider_chan2_enable_o
);

    // --------------------------------------------------------------
    // storage
    // --------------------------------------------------------------
    logic [7:0] pll2_loop_config;
    logic [7:0] watchdog_and_switch_control;
    logic [7:0] diff_output_common_control;
    logic [7:0] diff_output_one_control;
    logic [7:0] diff_output_two_control;
    logic [7:0] single_ended_and_divider_control;
    logic       alarm;

    cocr_wdog_if wd_if ();

    // --------------------------------------------------------------
    // decode
    // --------------------------------------------------------------
    wire        wr_pll2   = wr_i && (addr_i == COCR_ADDR_PLL2);
    wire        wr_wdog   = wr_i && (addr_i == COCR_ADDR_WDOG);
    wire        wr_com    = wr_i && (addr_i == COCR_ADDR_DIFFCOM);
    wire        wr_d1     = wr_i && (addr_i == COCR_ADDR_DIFF1);
    wire        wr_d2     = wr_i && (addr_i == COCR_ADDR_DIFF2);
    wire        wr_se     = wr_i && (addr_i == COCR_ADDR_SEDIV);
    wire        hit_any   = (addr_i >= COCR_ADDR_PLL2) && (addr_i <= COCR_ADDR_SEDIV);
    wire [7:0]  wdog_view = {watchdog_and_switch_control[7:1], alarm};
    wire [1:0]  type_one  = diff_output_one_control[COCR_B_TYPE_HI:COCR_B_TYPE_LO];
    wire [1:0]  type_two  = diff_output_two_control[COCR_B_TYPE_HI:COCR_B_TYPE_LO];
    wire        chip_pd   = !single_ended_and_divider_control[COCR_B_CHIP_PD_N];

    // only the writable bits take host data; reserved bits keep defaults
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
                                         input logic [7:0] mask);
        merge = (old & ~mask) | (wd & mask);
    endfunction

    wire [7:0] next_pll2 = merge(pll2_loop_config, wdata_i, COCR_WMASK_PLL2);
    wire [7:0] next_wdog = merge(watchdog_and_switch_control, wdata_i, COCR_WMASK_WDOG);
    wire [7:0] next_com  = merge(diff_output_common_control, wdata_i, COCR_WMASK_DIFFCOM);
    wire [7:0] next_d1   = merge(diff_output_one_control, wdata_i, COCR_WMASK_DIFF);
    wire [7:0] next_d2   = merge(diff_output_two_control, wdata_i, COCR_WMASK_DIFF);
    wire [7:0] next_se   = merge(single_ended_and_divider_control, wdata_i, COCR_WMASK_SEDIV);

    logic [7:0] next_rdata;
    always_comb begin
        unique case (addr_i)
            COCR_ADDR_PLL2:    next_rdata = pll2_loop_config;
            COCR_ADDR_WDOG:    next_rdata = wdog_view; // RULE2
            COCR_ADDR_DIFFCOM: next_rdata = diff_output_common_control;
            COCR_ADDR_DIFF1:   next_rdata = diff_output_one_control;
            COCR_ADDR_DIFF2:   next_rdata = diff_output_two_control;
            COCR_ADDR_SEDIV:   next_rdata = single_ended_and_divider_control;
            default:           next_rdata = 8'h00;
        endcase
    end

    // --------------------------------------------------------------
    // register writes
    // --------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pll2_loop_config                 <= COCR_RST_PLL2; // RULE4 RULE5 RULE6
            watchdog_and_switch_control      <= COCR_RST_WDOG; // RULE1
            diff_output_common_control       <= COCR_RST_DIFFCOM; // RULE7 RULE8
            diff_output_one_control          <= COCR_RST_DIFF1; // RULE9 RULE11
            diff_output_two_control          <= COCR_RST_DIFF2; // RULE10 RULE11
            single_ended_and_divider_control <= COCR_RST_SEDIV; // RULE14 RULE15 RULE16
        end else begin
            if (wr_pll2) pll2_loop_config <= next_pll2; // RULE4 RULE5 RULE6
            if (wr_wdog) watchdog_and_switch_control <= next_wdog; // RULE2
            if (wr_com)  diff_output_common_control <= next_com;
            if (wr_d1)   diff_output_one_control <= next_d1; // RULE12 RULE13
            if (wr_d2)   diff_output_two_control <= next_d2; // RULE12 RULE13
            if (wr_se)   single_ended_and_divider_control <= next_se;
        end
    end

    // --------------------------------------------------------------
    // watchdog and alarm
    // --------------------------------------------------------------
    // any host access to 0x1f..0x24 counts as activity; a write to 0x20 re-arms
    assign wd_if.enable      = watchdog_and_switch_control[COCR_B_WDOG_EN]; // RULE1
    assign wd_if.timeout_sel = watchdog_and_switch_control[COCR_B_TSEL_HI:COCR_B_TSEL_LO];
    assign wd_if.restart     = (wr_i || rd_i) && hit_any; // RULE3

    cocr_wdog #(
        .TICK_CYC (WD_TICK_CYC)
    ) u_wdog (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .wd    (wd_if.timer)
    );

    // expiry wins over a same-cycle reconfiguration
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm <= 1'b0;
        end else if (wd_if.expired) begin
            alarm <= 1'b1; // RULE3
        end else if (wr_wdog) begin
            alarm <= 1'b0; // RULE3
        end
    end

    // --------------------------------------------------------------
    // read data and outputs
    // --------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            rdata_o <= next_rdata; // RULE18
        end
    end

    always_ff @(posedge clk_i) begin
        second_loop_order_sel_o         <= pll2_loop_config[COCR_B_LOOP_ORDER]; // RULE4
        second_loop_chan2_enable_o      <= pll2_loop_config[COCR_B_CHAN2_EN]; // RULE5
        second_loop_extra_pole_enable_o <= pll2_loop_config[COCR_B_EXTRA_POLE]; // RULE6
        freq_switch_enable_o            <= watchdog_and_switch_control[COCR_B_FSW_EN];
        freq_switch_apply_o             <= freq_switch_select_i; // RULE17
        wdog_enable_o                   <= watchdog_and_switch_control[COCR_B_WDOG_EN];
        wdog_alarm_o                    <= alarm;
        pair_powerdown_tristate_o       <= diff_output_common_control[COCR_B_PD_TRISTATE];
        pair_hiz_o                      <= chip_pd && diff_output_common_control[COCR_B_PD_TRISTATE]; // RULE7
        pair_one_b_polarity_o           <= diff_output_common_control[COCR_B_ONE_POL]; // RULE8
        pair_two_b_polarity_o           <= diff_output_common_control[COCR_B_TWO_POL]; // RULE8
        pair_one_source_sel_o           <= diff_output_one_control[COCR_B_SRC]; // RULE9
        pair_two_source_sel_o           <= diff_output_two_control[COCR_B_SRC]; // RULE10
        pair_one_low_power_hcsl_type_o  <= (type_one == COCR_TYPE_LOW_POWER_HCSL); // RULE11
        pair_two_low_power_hcsl_type_o  <= (type_two == COCR_TYPE_LOW_POWER_HCSL); // RULE11
        pair_one_cmos_o                 <= (type_one == COCR_TYPE_CMOS); // RULE11
        pair_two_cmos_o                 <= (type_two == COCR_TYPE_CMOS); // RULE11
        pair_one_slew_o                 <= diff_output_one_control[COCR_B_SLEW]; // RULE12
        pair_two_slew_o                 <= diff_output_two_control[COCR_B_SLEW]; // RULE12
        pair_one_b_enable_o             <= diff_output_one_control[COCR_B_B_EN]; // RULE13
        pair_two_b_enable_o             <= diff_output_two_control[COCR_B_B_EN]; // RULE13
        chip_powerdown_n_o              <= single_ended_and_divider_control[COCR_B_CHIP_PD_N]; // RULE14
        ref_free_run_o                  <= single_ended_and_divider_control[COCR_B_REF_FREERUN];
        ref_enable_o                    <= single_ended_and_divider_control[COCR_B_REF_EN];
        single_out1_slow_clock_o        <= !single_ended_and_divider_control[COCR_B_SLOW_SEL]; // RULE15
        single_out1_divider_sel_o       <= single_ended_and_divider_control[COCR_B_DIV_SEL]; // RULE15
        fourth_divider_chan3_enable_o   <= single_ended_and_divider_control[COCR_B_D4_CH3_EN]; // RULE16
        fourth_divider_chan2_enable_o   <= single_ended_and_divider_control[COCR_B_D4_CH2_EN]; // RULE16
    end

endmodule

/* File: hw/cocr_pkg.sv */
// Purpose: constants for the clock output configuration register bank
// Assumes: 8-bit registers at byte addresses 0x1f..0x24
// Notes:   reserved bits hold their power-on values and are not writable
package cocr_pkg;

    // --------------------------------------------------------------
    // register addresses
    // --------------------------------------------------------------
    localparam logic [7:0] COCR_ADDR_PLL2     = 8'h1f;
    localparam logic [7:0] COCR_ADDR_WDOG     = 8'h20;
    localparam logic [7:0] COCR_ADDR_DIFFCOM  = 8'h21;
    localparam logic [7:0] COCR_ADDR_DIFF1    = 8'h22;
    localparam logic [7:0] COCR_ADDR_DIFF2    = 8'h23;
    localparam logic [7:0] COCR_ADDR_SEDIV    = 8'h24;

    // --------------------------------------------------------------
    // reset values and writable masks
    // --------------------------------------------------------------
    localparam logic [7:0] COCR_RST_PLL2      = 8'h04;
    localparam logic [7:0] COCR_WMASK_PLL2    = 8'h0e;
    localparam logic [7:0] COCR_RST_WDOG      = 8'h80;
    localparam logic [7:0] COCR_WMASK_WDOG    = 8'h1e;
    localparam logic [7:0] COCR_RST_DIFFCOM   = 8'hb0;
    localparam logic [7:0] COCR_WMASK_DIFFCOM = 8'h07;
    localparam logic [7:0] COCR_RST_DIFF1     = 8'hf4;
    localparam logic [7:0] COCR_RST_DIFF2     = 8'h34;
    localparam logic [7:0] COCR_WMASK_DIFF    = 8'hb3;
    localparam logic [7:0] COCR_RST_SEDIV     = 8'h8c;
    localparam logic [7:0] COCR_WMASK_SEDIV   = 8'hdf;

    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int COCR_B_LOOP_ORDER   = 3;
    localparam int COCR_B_CHAN2_EN     = 2;
    localparam int COCR_B_EXTRA_POLE   = 1;
    localparam int COCR_B_FSW_EN       = 4;
    localparam int COCR_B_WDOG_EN      = 3;
    localparam int COCR_B_TSEL_HI      = 2;
    localparam int COCR_B_TSEL_LO      = 1;
    localparam int COCR_B_ALARM        = 0;
    localparam int COCR_B_PD_TRISTATE  = 2;
    localparam int COCR_B_ONE_POL      = 1;
    localparam int COCR_B_TWO_POL      = 0;
    localparam int COCR_B_SRC          = 7;
    localparam int COCR_B_TYPE_HI      = 5;
    localparam int COCR_B_TYPE_LO      = 4;
    localparam int COCR_B_SLEW         = 1;
    localparam int COCR_B_B_EN         = 0;
    localparam int COCR_B_CHIP_PD_N    = 7;
    localparam int COCR_B_REF_FREERUN  = 6;
    localparam int COCR_B_SLOW_SEL     = 4;
    localparam int COCR_B_DIV_SEL      = 3;
    localparam int COCR_B_REF_EN       = 2;
    localparam int COCR_B_D4_CH3_EN    = 1;
    localparam int COCR_B_D4_CH2_EN    = 0;

    // --------------------------------------------------------------
    // output type codes
    // --------------------------------------------------------------
    localparam logic [1:0] COCR_TYPE_CMOS          = 2'h0;
    localparam logic [1:0] COCR_TYPE_LOW_POWER_HCSL = 2'h3;

    // --------------------------------------------------------------
    // watchdog timing
    // --------------------------------------------------------------
    localparam longint COCR_CLK_HZ     = 100000000;
    localparam longint COCR_TICK_US    = 1000;
    localparam int     COCR_TICK_CYC   = int'(COCR_CLK_HZ * COCR_TICK_US / 1000000);
    localparam int     COCR_WD_250_MS  = 250;
    localparam int     COCR_WD_500_MS  = 500;
    localparam int     COCR_WD_2_S     = 2;
    localparam int     COCR_WD_4_S     = 4;
    localparam int     COCR_MS_PER_S   = 1000;

endpackage

/* File: hw/cocr_wdog_if.sv */
// Purpose: carrier between register bank and watchdog timer
// Assumes: single clock domain
// Notes:   none
`timescale 1ns/1ps
interface cocr_wdog_if;
    logic       enable;
    logic [1:0] timeout_sel;
    logic       restart;
    logic       expired;

    modport bank  (output enable, output timeout_sel, output restart, input expired);
    modport timer (input enable, input timeout_sel, input restart, output expired);
endinterface

/* File: hw/cocr_wdog.sv */
// Purpose: watchdog timer with selectable timeout
// Assumes: tick period is one millisecond
// Notes:   expired is a one-cycle pulse; counter restarts on any restart pulse
`timescale 1ns/1ps
module cocr_wdog
    import cocr_pkg::*;
#(
    parameter int TICK_CYC = COCR_TICK_CYC
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // control
    cocr_wdog_if.timer wd
);

    logic [31:0] tick_cnt;
    logic [15:0] ms_cnt;
    logic [15:0] limit_ms;
    logic        tick;
    logic        at_limit;

    // --------------------------------------------------------------
    // timeout decode
    // --------------------------------------------------------------
    always_comb begin
        unique case (wd.timeout_sel)
            2'h0: limit_ms = 16'(COCR_WD_250_MS);
            2'h1: limit_ms = 16'(COCR_WD_500_MS);
            2'h2: limit_ms = 16'(COCR_WD_2_S * COCR_MS_PER_S);
            2'h3: limit_ms = 16'(COCR_WD_4_S * COCR_MS_PER_S);
        endcase
    end

    assign tick     = (tick_cnt == 32'(TICK_CYC - 1));
    assign at_limit = tick && (ms_cnt == limit_ms - 16'h0001);

    // --------------------------------------------------------------
    // counters
    // --------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i || !wd.enable || wd.restart) begin
            tick_cnt   <= 32'h0;
            ms_cnt     <= 16'h0;
            wd.expired <= 1'b0;
        end else begin
            tick_cnt   <= tick ? 32'h0 : tick_cnt + 32'h1;
            if (tick) begin
                ms_cnt <= at_limit ? 16'h0 : ms_cnt + 16'h1;
            end
            wd.expired <= at_limit; // RULE1
        end
    end

endmodule

/* File: bench/cocr_regs_checker.sv */
// Purpose: concurrent checks on the bank ports
// Assumes: one clock, synchronous active-high reset
// Notes:   a write shows on the outputs two edges later
`timescale 1ns/1ps
module cocr_regs_checker (
    // clock and reset
    input wire logic       clk_i,
    input wire logic       rst_i,
    // host port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    // observed outputs
    input wire logic       second_loop_order_sel_o,
    input wire logic       wdog_enable_o,
    input wire logic       wdog_alarm_o,
    input wire logic       pair_powerdown_tristate_o,
    input wire logic       pair_one_source_sel_o,
    input wire logic       pair_two_source_sel_o,
    input wire logic       pair_one_low_power_hcsl_type_o,
    input wire logic       pair_one_cmos_o,
    input wire logic       pair_hiz_o,
    input wire logic       chip_powerdown_n_o,
    input wire logic       single_out1_slow_clock_o
);
    // ----------------------------------------------------------
    // properties
    // ----------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_wr(logic [7:0] a); wr_i && addr_i == a; endsequence

    property p_order; s_wr(8'h1f) |-> ##2 second_loop_order_sel_o == $past(wdata_i[3], 2); endproperty
    a_order: assert property (p_order) else $error("loop order wrong");
    property p_src_one; s_wr(8'h22) |-> ##2 pair_one_source_sel_o == $past(wdata_i[7], 2); endproperty
    a_src_one: assert property (p_src_one) else $error("pair one source wrong");
    property p_src_two; s_wr(8'h23) |-> ##2 pair_two_source_sel_o == $past(wdata_i[7], 2); endproperty
    a_src_two: assert property (p_src_two) else $error("pair two source wrong");
    property p_type;
        s_wr(8'h22) |-> ##2 pair_one_cmos_o == ($past(wdata_i[5:4], 2) == 2'b00)
            && pair_one_low_power_hcsl_type_o == ($past(wdata_i[5:4], 2) == 2'b11);
    endproperty
    a_type: assert property (p_type) else $error("pair one type wrong");
    property p_slow; s_wr(8'h24) |-> ##2 single_out1_slow_clock_o == !$past(wdata_i[4], 2); endproperty
    a_slow: assert property (p_slow) else $error("slow clock wrong");
    property p_hiz; pair_hiz_o == (pair_powerdown_tristate_o && !chip_powerdown_n_o); endproperty
    a_hiz: assert property (p_hiz) else $error("tristate request wrong");
    property p_alarm_rd; rd_i && addr_i == 8'h20 |=> rdata_o[0] == wdog_alarm_o; endproperty
    a_alarm_rd: assert property (p_alarm_rd) else $error("alarm read back wrong");
    property p_alarm_en; $rose(wdog_alarm_o) |-> wdog_enable_o; endproperty
    a_alarm_en: assert property (p_alarm_en) else $error("alarm while watchdog off");
    property p_alarm_clr; s_wr(8'h20) ##0 !wdata_i[3] |-> ##2 !wdog_alarm_o; endproperty
    a_alarm_clr: assert property (p_alarm_clr) else $error("alarm not cleared");

    c_alarm: cover property ($rose(wdog_alarm_o));
    c_hiz: cover property ($rose(pair_hiz_o));
    c_src: cover property (s_wr(8'h22));
endmodule

bind cocr_regs cocr_regs_checker chk_u (.*);

/* File: bench/cocr_host_model.sv */
// Purpose: host that reads and writes the bank
// Assumes: one access per call, launched at a falling edge
// Notes:   released lines show the inverse of their last value
`timescale 1ns/1ps
module cocr_host_model (
    // clock
    input  wire logic       clk_i,
    // register port
    input  wire logic [7:0] rdata_i,
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            wr_o,
    output logic            rd_o
);
    initial {addr_o, wdata_o, wr_o, rd_o} = 18'h0;
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        {addr_o, wdata_o, wr_o} = {a, d, 1'b1};
        @(negedge clk_i);
        {addr_o, wdata_o, wr_o} = {~a, ~d, 1'b0};
    endtask
    // read data stands one edge after the strobe
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        {addr_o, rd_o} = {a, 1'b1};
        @(negedge clk_i);
        {addr_o, rd_o} = {~a, 1'b0};
        d = rdata_i;
    endtask
endmodule

/* File: bench/tb_top.sv */
// Purpose: self-checking bench for the output configuration bank
// Assumes: watchdog tick shortened to TICK cycles
// Notes:   a shadow of the six registers gives every expected output except alarm and switch apply
`timescale 1ns/1ps
module tb_top;
    import cocr_pkg::*;
    // ----------------------------------------------------------
    // setup
    // ----------------------------------------------------------
    localparam int TICK = 2;
    localparam logic [7:0] RST [6] = '{COCR_RST_PLL2, COCR_RST_WDOG, COCR_RST_DIFFCOM,
                                        COCR_RST_DIFF1, COCR_RST_DIFF2, COCR_RST_SEDIV};
    localparam logic [7:0] WM [6] = '{COCR_WMASK_PLL2, COCR_WMASK_WDOG, COCR_WMASK_DIFFCOM,
                                       COCR_WMASK_DIFF, COCR_WMASK_DIFF, COCR_WMASK_SEDIV};
    localparam logic [7:0] FLD [12] = '{8'h08, 8'h10, 8'h05, 8'h00, 8'hb3, 8'h13,
                                         8'h06, 8'h00, 8'h02, 8'hb1, 8'h02, 8'h88};
    localparam int MS [4] = '{COCR_WD_250_MS, COCR_WD_500_MS, COCR_WD_2_S*COCR_MS_PER_S, COCR_WD_4_S*COCR_MS_PER_S};
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [1:0]  fsel = 2'h0;
    logic [7:0]  addr, wdata, rdata, shadow [6];
    logic        wr, rd, alarm;
    logic [1:0]  fapply;
    wire  [25:0] outs;
    int          mismatches = 0;
    int          samples_checked = 0;

    always #5 clk_i = ~clk_i;

    cocr_host_model host_u (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    cocr_regs #(.WD_TICK_CYC(TICK)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .freq_switch_select_i(fsel), .freq_switch_apply_o(fapply), .wdog_alarm_o(alarm),
        .second_loop_order_sel_o(outs[0]), .second_loop_chan2_enable_o(outs[1]),
        .second_loop_extra_pole_enable_o(outs[2]), .freq_switch_enable_o(outs[3]), .wdog_enable_o(outs[4]),
        .pair_powerdown_tristate_o(outs[5]), .pair_one_b_polarity_o(outs[6]), .pair_two_b_polarity_o(outs[7]),
        .pair_one_source_sel_o(outs[8]), .pair_two_source_sel_o(outs[9]),
        .pair_one_low_power_hcsl_type_o(outs[10]), .pair_two_low_power_hcsl_type_o(outs[11]),
        .pair_one_cmos_o(outs[12]), .pair_two_cmos_o(outs[13]), .pair_one_slew_o(outs[14]),
        .pair_two_slew_o(outs[15]), .pair_one_b_enable_o(outs[16]), .pair_two_b_enable_o(outs[17]),
        .pair_hiz_o(outs[18]), .chip_powerdown_n_o(outs[19]), .ref_free_run_o(outs[20]), .ref_enable_o(outs[21]),
        .single_out1_slow_clock_o(outs[22]), .single_out1_divider_sel_o(outs[23]),
        .fourth_divider_chan3_enable_o(outs[24]), .fourth_divider_chan2_enable_o(outs[25]));

    function automatic logic [25:0] model_outs();
        logic [7:0] p = shadow[0], w = shadow[1], c = shadow[2], a = shadow[3], b = shadow[4], s = shadow[5];
        return {s[0], s[1], s[3], ~s[4], s[2], s[6], s[7], c[2] & ~s[7], b[0], a[0], b[1], a[1],
                b[5:4] == 2'b00, a[5:4] == 2'b00, b[5:4] == 2'b11, a[5:4] == 2'b11,
                b[7], a[7], c[0], c[1], c[2], w[3], w[4], p[1], p[2], p[3]};
    endfunction
    function automatic logic [7:0] keep(input int i, input logic [7:0] d);
        return (d & WM[i]) | (RST[i] & ~WM[i]);
    endfunction
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input int i, input logic [7:0] d);
        host_u.write_reg(COCR_ADDR_PLL2 + 8'(i), d);
        shadow[i] = keep(i, d);
    endtask
    task automatic rd_chk(input int i, input logic [7:0] e);
        logic [7:0] d;
        host_u.read_reg(COCR_ADDR_PLL2 + 8'(i), d);
        chk("register", 32'(d), 32'(e));
    endtask
    task automatic outs_chk();
        @(negedge clk_i);
        chk("outputs", 32'(outs), 32'(model_outs()));
    endtask
    task automatic t_reset();
        logic [7:0] d;
        for (int i = 0; i < 6; i++) begin
            shadow[i] = RST[i];
            rd_chk(i, RST[i]);
        end
        outs_chk();
        host_u.read_reg(8'h25, d);
        chk("unmapped", 32'(d), 32'h0);
        $display("done reset values");
    endtask
    task automatic t_masks();
        logic [7:0] d;
        for (int i = 0; i < 6; i++) begin
            wr_reg(i, 8'hff);
            rd_chk(i, shadow[i]);
            outs_chk();
            wr_reg(i, 8'h00);
            rd_chk(i, shadow[i]);
            outs_chk();
            wr_reg(i, RST[i]);
        end
        host_u.write_reg(8'h25, 8'hff);
        host_u.read_reg(8'h25, d);
        chk("unmapped", 32'(d), 32'h0);
        $display("done write masks");
    endtask
    task automatic t_fields();
        for (int i = 0; i < 12; i++) begin
            wr_reg(i % 6, keep(i % 6, FLD[i]));
            outs_chk();
        end
        for (int k = 0; k < 4; k++) begin
            fsel = 2'(k);
            @(negedge clk_i);
            chk("switch apply", 32'(fapply), k);
        end
        for (int i = 0; i < 6; i++) wr_reg(i, RST[i]);
        $display("done field decode");
    endtask
    task automatic t_wdog(input logic [1:0] sel);
        int lim = MS[sel] * TICK;
        wr_reg(1, keep(1, {5'h01, sel, 1'b0}));
        repeat (lim - 6) @(negedge clk_i);
        chk("early alarm", 32'(alarm), 32'h0);
        for (int n = 0; n < 14 && alarm !== 1'b1; n++) @(negedge clk_i);
        chk("alarm", 32'(alarm), 32'h1);
        rd_chk(1, shadow[1] | 8'h01);
        wr_reg(1, keep(1, 8'h00));
        rd_chk(1, shadow[1]);
        $display("done watchdog select %0d", sel);
    endtask
    task automatic t_restart();
        int lim = MS[0] * TICK;
        wr_reg(1, keep(1, 8'h08));
        repeat (lim * 3 / 5) @(negedge clk_i);
        rd_chk(0, shadow[0]);
        repeat (lim * 3 / 5) @(negedge clk_i);
        chk("restarted alarm", 32'(alarm), 32'h0);
        wr_reg(1, keep(1, 8'h00));
        repeat (lim + 20) @(negedge clk_i);
        chk("disabled alarm", 32'(alarm), 32'h0);
        $display("done watchdog restart");
    endtask
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(negedge clk_i);
        rst_i = 1'b0;
        t_reset();
        t_masks();
        t_fields();
        for (int s = 0; s < 4; s++) t_wdog(2'(s));
        t_restart();
        print_verdict();
    end
    // run needs about fifteen thousand cycles
    initial begin
        repeat (60000) @(posedge clk_i);
        mismatches++;
        print_verdict();
    end
endmodule
